// ==== hdl/dmcp_device.sv ====
/*
 Device end: two-wire / four-wire slave with a 128-byte register page.
 Assumes link_clk oversamples the host's serial clocks at least four
 times per phase; srst, ce and user inputs come from the clk domain.
*/
// Contract
// R1: Bytes are eight bits, MSB first, acknowledged.
// R2: Start and stop framed by data while clock high.
// R3: Data changes only while clock is low.
// R4: Slave address is 10011 plus strap bits.
// R5: Device pulls data low during acknowledge clock.
// R6: Any number of bytes between start and stop.
// R7: Select pin sampled at power-up picks mode.
// R8: Four-wire mode is slave only, host clocks.
// R9: Four-wire shifts out while shifting in.
// R10: Clock phase one, drive on first edge.
// R11: First byte after select fall is command.
// R12: Command holds address bits 7-1, direction bit 0.
// R13: Four-wire write stores second byte.
// R14: Four-wire read shifts register out second byte.
// R15: Host writes reserved bits with defaults.
// R16: Multi-byte read returns consecutive registers while acked.
// R17: Sequential write increments register from start address.
// R18: Write: start, address, register, data, stop.
// R19: Every received write data byte is acknowledged.
// R20: Read: register write, repeated start, read, nack.
// R21: Global address answered while its enable is set.
// R22: Paged space, page and book zero after reset.
// R23: Unmatched address gets no acknowledge, ignored.
// R24: Select fall restarts the bit counter.
`timescale 1ns/10ps
`default_nettype none
module dmcp_device
	import dmcp_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       ce,
	input  wire logic       link_clk,
	input  wire logic [1:0] address_strap_level,
	input  wire logic       global_address_enable,
	output var  logic       four_wire_mode,
	output var  logic       reg_write_stb,
	output var  logic [6:0] reg_write_addr,
	output var  logic [7:0] reg_write_data,
	dmcp_link_if.device     lk
);
	typedef struct packed {
		logic [SY_W-1:0]  s1;
		logic [SY_W-1:0]  s2;
		logic [SY_W-1:0]  p;
		logic             booted;
		logic             four_wire;
		logic [6:0]       saddr;
		dmcp_dev_st_t     st;
		dmcp_kind_t       kind;
		logic             dir_rd;
		logic [4:0]       cnt;
		logic [7:0]       sh;
		logic [7:0]       tx;
		logic [6:0]       ptr;
		logic [127:0][7:0] regs;
		logic             dat_oe;
		logic             so_o;
		logic             so_oe;
		logic             wr_tgl;
		logic [6:0]       wr_addr;
		logic [7:0]       wr_data;
	} dmcp_dev_link_t;

	typedef struct packed {
		logic [2:0] t;
		logic [1:0] m;
		logic       stb;
		logic [6:0] addr;
		logic [7:0] data;
	} dmcp_dev_sys_t;

	dmcp_dev_link_t q, next_q;
	dmcp_dev_sys_t  u, next_u;

	// Other pages are not built: apart from the page and book registers they read as zero, writes are dropped
	function automatic logic page_zero(input dmcp_dev_link_t s,
			input logic [6:0] a);
		return (a == PAGE_REG) || (a == BOOK_REG) ||
			(s.regs[PAGE_REG] == REG_RESET &&
			s.regs[BOOK_REG] == REG_RESET);
	endfunction

	function automatic logic [7:0] reg_read(input dmcp_dev_link_t s,
			input logic [6:0] a);
		return page_zero(s, a) ? s.regs[a] : REG_RESET; // [R22]
	endfunction

	always_comb begin
		logic       scl;
		logic       sda;
		logic       sck;
		logic       scl_r;
		logic       scl_f;
		logic       sck_r;
		logic       sck_f;
		logic       do_wr;
		logic       match;
		logic [6:0] wa;
		logic [7:0] wd;
		logic [7:0] nsh;
		logic [7:0] v;
		scl   = q.s2[SY_WCS];
		sda   = q.s2[SY_DAT];
		sck   = q.s2[SY_SCK];
		scl_r = scl && !q.p[SY_WCS];
		scl_f = !scl && q.p[SY_WCS];
		sck_r = sck && !q.p[SY_SCK];
		sck_f = !sck && q.p[SY_SCK];
		do_wr = 1'b0;
		wa    = q.ptr;
		wd    = q.sh;
		nsh   = {q.sh[6:0], sda}; // [R1]
		v     = reg_read(q, q.ptr);
		match = (q.sh[7:1] == q.saddr) ||
			(q.s2[SY_GBL] && q.sh[7:1] == GLOBAL_ADDR); // [R21]
		next_q = q;
		next_q.s1 = {address_strap_level, lk.interface_select_slave_out_pin,
			lk.data_line, lk.address_strap_serial_clock_pin,
			lk.wire_clock_select_pin, global_address_enable, ce, srst};
		next_q.s2 = q.s1;
		next_q.p  = q.s2;
		if (q.s2[SY_RST]) begin
			next_q.booted    = 1'b0;
			next_q.four_wire = 1'b0;
			next_q.saddr     = '0;
			next_q.st        = DS_IDLE;
			next_q.kind      = BK_SADDR;
			next_q.dir_rd    = 1'b0;
			next_q.cnt       = '0;
			next_q.sh        = '0;
			next_q.tx        = '0;
			next_q.ptr       = '0;
			next_q.regs      = {128{REG_RESET}}; // [R22]
			next_q.dat_oe    = 1'b0;
			next_q.so_o      = 1'b0;
			next_q.so_oe     = 1'b0;
			next_q.wr_tgl    = 1'b0;
			next_q.wr_addr   = '0;
			next_q.wr_data   = '0;
		end else if (!q.s2[SY_CE]) begin
			next_q.p = q.p;
		end else if (!q.booted) begin
			// Straps caught once, on the first edge after reset
			next_q.booted    = 1'b1;
			next_q.four_wire = q.s2[SY_SO]; // [R7]
			next_q.saddr     = {STRAP_BASE, q.s2[SY_STRAP +: 2]}; // [R4]
		end else if (!q.four_wire) begin
			if (scl && q.p[SY_WCS] && !sda && q.p[SY_DAT]) begin
				// Start or repeated start from any state [R2]
				next_q.st     = DS_RX;
				next_q.kind   = BK_SADDR;
				next_q.cnt    = '0;
				next_q.dat_oe = 1'b0;
			end else if (scl && q.p[SY_WCS] && sda && !q.p[SY_DAT]) begin
				next_q.st     = DS_IDLE; // [R2] [R6]
				next_q.dat_oe = 1'b0;
			end else begin
				unique case (q.st)
				DS_RX: begin
					if (scl_r) begin
						next_q.sh  = nsh; // [R1] [R3]
						next_q.cnt = q.cnt + 5'h01;
					end else if (scl_f && q.cnt == BYTE_BITS) begin
						next_q.st     = DS_ACK;
						next_q.dat_oe = 1'b1; // [R5] [R19]
						unique case (q.kind)
						BK_SADDR: begin
							next_q.dir_rd = q.sh[0];
							next_q.kind   = BK_REG;
							if (!match) begin
								next_q.st     = DS_IGN; // [R23]
								next_q.dat_oe = 1'b0;
							end
						end
						BK_REG: begin
							next_q.ptr  = q.sh[6:0];
							next_q.kind = BK_DATA;
						end
						default: begin
							do_wr      = 1'b1;
							next_q.ptr = q.ptr + 7'h01; // [R17]
						end
						endcase
					end
				end
				DS_ACK: begin
					if (scl_f) begin
						next_q.dat_oe = 1'b0;
						next_q.cnt    = '0;
						next_q.st     = DS_RX; // [R6]
						if (q.dir_rd == DIR_READ) begin
							next_q.tx     = v;
							next_q.ptr    = q.ptr + 7'h01; // [R16]
							next_q.dat_oe = !v[7];
							next_q.st     = DS_TX;
						end
					end
				end
				DS_TX: begin
					if (scl_r) begin
						next_q.cnt = q.cnt + 5'h01;
					end else if (scl_f && q.cnt == BYTE_BITS) begin
						next_q.dat_oe = 1'b0;
						next_q.st     = DS_RACK;
					end else if (scl_f) begin
						next_q.tx     = {q.tx[6:0], 1'b0}; // [R1]
						next_q.dat_oe = !q.tx[6];
					end
				end
				DS_RACK: begin
					// Master nack ends the read until the stop
					if (scl_r) begin
						next_q.st = sda ? DS_IGN : DS_ACK; // [R16]
					end
				end
				DS_IDLE, DS_IGN: begin
				end
				endcase
			end
		end else begin
			// Four-wire: select on the clock pin's twin [R8]
			if (!scl && q.p[SY_WCS]) begin
				next_q.st  = DS_RX; // [R11] [R24]
				next_q.cnt = '0;
				next_q.tx  = '0;
			end else if (scl) begin
				next_q.st = DS_IDLE;
			end else if (q.st == DS_RX && sck_r) begin
				next_q.so_o = q.tx[7]; // [R9] [R10]
				next_q.tx   = {q.tx[6:0], 1'b0};
			end else if (q.st == DS_RX && sck_f) begin
				next_q.sh  = nsh;
				next_q.cnt = q.cnt + 5'h01;
				if (q.cnt == BYTE_BITS - 5'h01) begin
					next_q.ptr    = nsh[7:1]; // [R12]
					next_q.dir_rd = nsh[0];
					if (nsh[0] == DIR_READ) begin
						next_q.tx = reg_read(q, nsh[7:1]); // [R14]
					end
				end
				if (q.cnt == FRAME_BITS - 5'h01) begin
					next_q.st = DS_IGN; // [R11]
					if (q.dir_rd != DIR_READ) begin
						do_wr = 1'b1; // [R13]
						wd    = nsh;
					end
				end
			end
			next_q.so_oe = !scl; // [R8]
		end
		if (do_wr && page_zero(q, wa)) begin
			next_q.regs[wa] = wd; // [R13] [R17]
			next_q.wr_tgl   = !q.wr_tgl;
			next_q.wr_addr  = wa;
			next_q.wr_data  = wd;
		end
	end

	always_ff @(posedge link_clk) begin
		q <= next_q;
	end

	// Write events cross by toggle; address and data are stable by then
	always_comb begin
		next_u = u;
		if (srst) begin
			next_u = '0;
		end else if (ce) begin
			next_u.t   = {u.t[1:0], q.wr_tgl};
			next_u.m   = {u.m[0], q.four_wire};
			next_u.stb = u.t[2] != u.t[1];
			if (u.t[2] != u.t[1]) begin
				next_u.addr = q.wr_addr;
				next_u.data = q.wr_data;
			end
		end
	end

	always_ff @(posedge clk) begin
		u <= next_u;
	end

	assign four_wire_mode = u.m[1];
	assign reg_write_stb  = u.stb;
	assign reg_write_addr = u.addr;
	assign reg_write_data = u.data;
	assign lk.dev_data_oe = q.dat_oe;
	assign lk.dev_so_o    = q.so_o;
	assign lk.dev_so_oe   = q.so_oe;
endmodule
`default_nettype wire

// ==== inc/dmcp_pkg.sv ====
/*
 Constants and types shared by both ends of the dual mode control port.
 Assumes a 20 MHz system clock on both ends.
*/
package dmcp_pkg;
	localparam int         CLK_NS      = 50;
	localparam int         LINK_BIT_NS = 2500;
	localparam int         QTR_CYC_INT =
		(LINK_BIT_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);
	localparam logic [7:0] QTR_CYC     = 8'(QTR_CYC_INT);
	localparam logic [4:0] STRAP_BASE  = 5'h13;
	localparam logic [6:0] GLOBAL_ADDR = 7'h48;
	localparam logic [6:0] PAGE_REG    = 7'h00;
	localparam logic [6:0] BOOK_REG    = 7'h7f;
	localparam logic [7:0] REG_RESET   = 8'h00;
	localparam logic       DIR_READ    = 1'h1;
	localparam logic [4:0] BYTE_BITS   = 5'h08;
	localparam logic [4:0] FRAME_BITS  = 5'h10;
	// Positions in the device's synchroniser vector
	localparam int SY_RST   = 0;
	localparam int SY_CE    = 1;
	localparam int SY_GBL   = 2;
	localparam int SY_WCS   = 3;
	localparam int SY_SCK   = 4;
	localparam int SY_DAT   = 5;
	localparam int SY_SO    = 6;
	localparam int SY_STRAP = 7;
	localparam int SY_W     = 9;
	typedef enum logic [2:0] {
		DS_IDLE = 3'h0, DS_RX = 3'h1, DS_ACK = 3'h2,
		DS_TX = 3'h3, DS_RACK = 3'h4, DS_IGN = 3'h5
	} dmcp_dev_st_t;
	typedef enum logic [1:0] {
		BK_SADDR = 2'h0, BK_REG = 2'h1, BK_DATA = 2'h2
	} dmcp_kind_t;
	typedef enum logic [2:0] {
		OP_START = 3'h0, OP_BYTE = 3'h1, OP_RDBYTE = 3'h2,
		OP_STOP = 3'h3, OP_DONE = 3'h4
	} dmcp_op_t;
	typedef enum logic {HS_IDLE = 1'h0, HS_RUN = 1'h1} dmcp_host_st_t;
endpackage

// ==== inc/dmcp_link_if.sv ====
/*
 Pins between host and device.
 Assumes the bench drives select_strap, the pull level of the shared
 select / slave-out pin seen while the device does not drive it.
*/
`timescale 1ns/10ps
`default_nettype none
interface dmcp_link_if;
	logic wire_clock_select_pin;
	logic address_strap_serial_clock_pin;
	logic host_data_o;
	logic host_data_oe;
	logic dev_data_oe;
	logic dev_so_o;
	logic dev_so_oe;
	logic select_strap;
	logic data_line;
	logic interface_select_slave_out_pin;
	// Wired-AND data line with pull-up; device only pulls low
	assign data_line = !((host_data_oe && !host_data_o) || dev_data_oe);
	assign interface_select_slave_out_pin =
		dev_so_oe ? dev_so_o : select_strap;
	modport device (
		input  wire_clock_select_pin,
		input  address_strap_serial_clock_pin,
		input  data_line,
		input  interface_select_slave_out_pin,
		output dev_data_oe,
		output dev_so_o,
		output dev_so_oe
	);
	modport host (
		output wire_clock_select_pin,
		output address_strap_serial_clock_pin,
		output host_data_o,
		output host_data_oe,
		input  data_line,
		input  interface_select_slave_out_pin
	);
endinterface
`default_nettype wire

// ==== hdl/dmcp_host.sv ====
/*
 Host end: makes the serial clocks by dividing clk and runs one
 single-byte register write or read in two-wire or four-wire mode.
 Assumes the device mode strap matches the four_wire input.
*/
`timescale 1ns/10ps
`default_nettype none
module dmcp_host
	import dmcp_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       ce,
	input  wire logic       four_wire,
	input  wire logic [6:0] target_address,
	input  wire logic       req_valid,
	output var  logic       req_ready,
	input  wire logic       req_read,
	input  wire logic [6:0] req_reg,
	input  wire logic [7:0] req_data,
	output var  logic       rsp_valid,
	output var  logic [7:0] rsp_data,
	output var  logic       rsp_nack,
	dmcp_link_if.host       lk
);
	typedef struct packed {
		logic [1:0]    ds;
		logic [1:0]    ms;
		dmcp_host_st_t st;
		logic          fw;
		logic          rd;
		logic [6:0]    taddr;
		logic [6:0]    rreg;
		logic [7:0]    rdat;
		logic [2:0]    seg;
		logic [1:0]    ph;
		logic [3:0]    bitn;
		logic [7:0]    div;
		logic [7:0]    sh;
		logic [7:0]    rx;
		logic          nack;
		logic          wcs;
		logic          sclk;
		logic          dout;
		logic          doe;
		logic          rsp_valid;
		logic [7:0]    rsp_data;
		logic          rsp_nack;
	} dmcp_host_t;

	dmcp_host_t q, next_q;

	function automatic dmcp_op_t op_of(input logic fw, input logic rd,
			input logic [2:0] g);
		if (fw) begin
			case (g)
			3'h0: return OP_START;
			3'h1, 3'h2: return OP_BYTE;
			3'h3: return OP_STOP;
			default: return OP_DONE;
			endcase
		end
		if (!rd) begin
			case (g)
			3'h0: return OP_START;
			3'h1, 3'h2, 3'h3: return OP_BYTE; // [R18]
			3'h4: return OP_STOP;
			default: return OP_DONE;
			endcase
		end
		case (g)
		3'h0, 3'h3: return OP_START; // [R20]
		3'h1, 3'h2, 3'h4: return OP_BYTE;
		3'h5: return OP_RDBYTE;
		3'h6: return OP_STOP;
		default: return OP_DONE;
		endcase
	endfunction

	function automatic logic [7:0] byte_of(input dmcp_host_t s,
			input logic [2:0] g);
		if (s.fw) begin
			if (g == 3'h1) begin
				return {s.rreg, s.rd}; // [R12]
			end
			return s.rd ? 8'h00 : s.rdat; // [R13]
		end
		case (g)
		3'h1: return {s.taddr, ~DIR_READ};
		3'h2: return {1'b0, s.rreg};
		3'h4: return {s.taddr, DIR_READ};
		default: return s.rdat;
		endcase
	endfunction

	always_comb begin
		dmcp_op_t   op;
		logic       adv;
		logic [3:0] lastb;
		logic [2:0] g;
		op     = op_of(q.fw, q.rd, q.seg);
		adv    = 1'b0;
		lastb  = q.fw ? 4'h7 : 4'h8;
		g      = q.seg + 3'h1;
		next_q = q;
		if (srst) begin
			next_q      = '0;
			next_q.st   = HS_IDLE;
			next_q.wcs  = 1'b1;
		end else if (ce) begin
			next_q.ds        = {q.ds[0], lk.data_line};
			next_q.ms        = {q.ms[0], lk.interface_select_slave_out_pin};
			next_q.rsp_valid = 1'b0;
			if (q.st == HS_IDLE) begin
				if (req_valid) begin
					next_q.st    = HS_RUN;
					next_q.fw    = four_wire;
					next_q.rd    = req_read;
					next_q.taddr = target_address;
					next_q.rreg  = req_reg;
					next_q.rdat  = req_data; // [R15]
					next_q.seg   = '0;
					next_q.ph    = '0;
					next_q.bitn  = '0;
					next_q.div   = '0;
					next_q.nack  = 1'b0;
					next_q.rx    = '0;
				end
			end else if (q.div != QTR_CYC - 8'h01) begin
				next_q.div = q.div + 8'h01;
			end else begin
				next_q.div = '0;
				next_q.ph  = q.ph + 2'h1;
				unique case (op)
				OP_START: begin
					unique case (q.ph)
					2'h0: begin
						next_q.wcs = 1'b0;
						next_q.doe = q.fw;
					end
					2'h1: next_q.wcs = !q.fw;
					2'h2: begin
						next_q.doe  = 1'b1; // [R2]
						next_q.dout = 1'b0;
					end
					2'h3: begin
						next_q.wcs = 1'b0;
						adv        = 1'b1;
					end
					endcase
				end
				OP_BYTE, OP_RDBYTE: begin
					unique case (q.ph)
					2'h0: begin
						// Data set while the clock is low in two-wire, on the serial clock rise in four-wire [R3] [R10]
						next_q.sclk = q.fw;
						next_q.dout = q.fw && q.sh[7];
						next_q.doe  = q.fw || (op == OP_BYTE &&
							q.bitn != 4'h8 && !q.sh[7]); // [R1]
					end
					2'h1: next_q.wcs = !q.fw;
					2'h2: begin
						next_q.sclk = 1'b0;
						if (q.fw) begin
							next_q.rx = {q.rx[6:0], q.ms[1]}; // [R9]
						end else if (q.bitn != 4'h8) begin
							next_q.rx = {q.rx[6:0], q.ds[1]};
						end else if (op == OP_BYTE && q.ds[1]) begin
							next_q.nack = 1'b1; // [R5]
						end
					end
					2'h3: begin
						next_q.wcs  = q.fw ? q.wcs : 1'b0;
						next_q.sh   = {q.sh[6:0], 1'b0};
						next_q.bitn = q.bitn + 4'h1;
						if (q.bitn == lastb) begin
							next_q.bitn = '0;
							adv         = 1'b1;
						end
					end
					endcase
				end
				OP_STOP: begin
					unique case (q.ph)
					2'h0: begin
						next_q.wcs  = q.fw ? q.wcs : 1'b0;
						next_q.doe  = 1'b1;
						next_q.dout = 1'b0;
					end
					2'h1: next_q.wcs = 1'b1;
					2'h2: begin
						next_q.wcs = 1'b1; // [R6]
						next_q.doe = q.fw;
					end
					2'h3: adv = 1'b1;
					endcase
				end
				default: begin
					next_q.st        = HS_IDLE;
					next_q.rsp_valid = 1'b1;
					next_q.rsp_data  = q.rx;
					next_q.rsp_nack  = q.nack;
				end
				endcase
				if (adv) begin
					// A refused byte skips straight to the stop
					if (!q.fw && next_q.nack && op == OP_BYTE) begin
						g = q.rd ? 3'h6 : 3'h4;
					end
					next_q.seg = g;
					next_q.sh  = byte_of(q, g);
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		q <= next_q;
	end

	assign req_ready   = (q.st == HS_IDLE) && ce && !srst;
	assign rsp_valid   = q.rsp_valid;
	assign rsp_data    = q.rsp_data;
	assign rsp_nack    = q.rsp_nack;
	assign lk.wire_clock_select_pin          = q.wcs;
	assign lk.address_strap_serial_clock_pin = q.sclk;
	assign lk.host_data_o                    = q.dout;
	assign lk.host_data_oe                   = q.doe;
endmodule
`default_nettype wire

// ==== test/dmcp_link_monitor.sv ====
/*
 Concurrent checks on the link between host and device.
 Assumes it sees the one interface that joins the two ends, on clk.
*/
`timescale 1ns/10ps
`default_nettype none
module dmcp_link_monitor (
	input wire logic clk,
	input wire logic srst,
	input wire logic select_strap,
	input wire logic wire_clock_select_pin,
	input wire logic address_strap_serial_clock_pin,
	input wire logic data_line,
	input wire logic dev_data_oe,
	input wire logic dev_so_o,
	input wire logic dev_so_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	logic       fw;
	logic       rd;
	logic       nb;
	logic [3:0] cnt;
	logic       scl;
	assign scl = wire_clock_select_pin;
	// Bit slot within the byte, so acks can be placed
	always_ff @(posedge clk) begin
		if (srst) begin
			fw  <= select_strap;
			cnt <= 4'h0;
			nb  <= 1'h0;
			rd  <= 1'h0;
		end else if (scl && $past(scl) && $fell(data_line)) begin
			cnt <= 4'h0;
			nb  <= 1'h0;
			rd  <= 1'h0;
		end else if ($rose(scl)) begin
			cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
			nb  <= nb || (cnt == 4'h8);
			rd  <= (cnt == 4'h7 && !nb) ? data_line : rd;
		end
	end
	a_drive_clock_low: assert property (!fw && $changed(dev_data_oe) |-> !scl)
		else $error("device data drive moved while clock high");
	a_ack_held_high: assert property (!fw && $rose(scl) && dev_data_oe |-> dev_data_oe[*8])
		else $error("device low level not held through clock high");
	a_ack_ninth_slot: assert property (!fw && !rd && $rose(dev_data_oe) |-> cnt == 4'h8)
		else $error("device pulled data low outside the ninth bit");
	a_start_clock_low: assert property (!fw && scl && $past(scl) && $fell(data_line) |-> ##[8:16] !scl)
		else $error("start not followed by clock low");
	a_stop_bus_idle: assert property (!fw && scl && $past(scl) && $rose(data_line) |-> (scl && data_line)[*8])
		else $error("bus not idle after stop");
	a_two_wire_quiet: assert property (!fw |-> !dev_so_oe)
		else $error("slave out driven in two-wire mode");
	a_four_wire_nosda: assert property (fw |-> !dev_data_oe)
		else $error("data line pulled in four-wire mode");
	a_select_drives: assert property (fw && $fell(scl) |-> ##[1:16] dev_so_oe)
		else $error("slave out not driven after select fall");
	a_deselect_frees: assert property (fw && $rose(scl) |-> ##[1:16] !dev_so_oe)
		else $error("slave out still driven after select rise");
	a_out_on_rise: assert property (fw && dev_so_oe && $past(dev_so_oe) && $changed(dev_so_o) |-> address_strap_serial_clock_pin)
		else $error("slave out changed while serial clock low");
	c_ack: cover property (!fw && $rose(dev_data_oe));
	c_stop: cover property (!fw && scl && $past(scl) && $rose(data_line));
	c_frame: cover property (fw && $fell(scl));
endmodule
`default_nettype wire

// ==== test/dual_mode_control_port_test.sv ====
/*
 Self-checking bench: host and device joined by one link, with a model.
 Assumes design files, interface and link monitor compile first.
*/
`timescale 1ns/10ps
`default_nettype none
module dual_mode_control_port_test
	import dmcp_pkg::*;
;
	logic        clk;
	logic        link_clk;
	logic        srst;
	logic        ce;
	logic [1:0]  strap;
	logic        gen;
	logic        fw;
	logic [6:0]  tgt;
	logic        rv;
	logic        rdy;
	logic        rrd;
	logic [6:0]  rreg;
	logic [7:0]  rdat;
	logic        rsv;
	logic [7:0]  rsd;
	logic        rsn;
	logic        fwm;
	logic        wstb;
	logic [6:0]  waddr;
	logic [7:0]  wdata;
	logic [6:0]  ra;
	int          errors;
	int          total_checks;
	int          seed;
	int          mem [128];
	logic [14:0] wq [$];
	dmcp_link_if lk ();
	dmcp_host dmcp_host_inst (.clk(clk), .srst(srst), .ce(ce), .four_wire(fw),
		.target_address(tgt), .req_valid(rv), .req_ready(rdy), .req_read(rrd),
		.req_reg(rreg), .req_data(rdat), .rsp_valid(rsv), .rsp_data(rsd),
		.rsp_nack(rsn), .lk(lk));
	dmcp_device dmcp_device_inst (.clk(clk), .srst(srst), .ce(ce),
		.link_clk(link_clk), .address_strap_level(strap),
		.global_address_enable(gen), .four_wire_mode(fwm),
		.reg_write_stb(wstb), .reg_write_addr(waddr),
		.reg_write_data(wdata), .lk(lk));
	dmcp_link_monitor dmcp_link_monitor_inst (.clk(clk), .srst(srst),
		.select_strap(lk.select_strap),
		.wire_clock_select_pin(lk.wire_clock_select_pin),
		.address_strap_serial_clock_pin(lk.address_strap_serial_clock_pin),
		.data_line(lk.data_line), .dev_data_oe(lk.dev_data_oe),
		.dev_so_o(lk.dev_so_o), .dev_so_oe(lk.dev_so_oe));
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	// Link clock free running, offset so no edge lines up with clk
	initial begin
		link_clk = 1'h0;
		#7;
		forever #62.5 link_clk = ~link_clk;
	end
	always @(posedge clk) begin
		if (wstb === 1'h1) begin
			wq.push_back({waddr, wdata});
		end
	end
	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Straps must be steady before reset falls, so set them with it
	task automatic boot(input logic f);
		lk.select_strap <= f;
		fw <= f;
		strap <= 2'($random(seed));
		srst <= 1'h1;
		repeat (12) @(posedge clk);
		srst <= 1'h0;
		foreach (mem[i]) mem[i] = 0;
		repeat (40) @(posedge clk);
		wq.delete();
		chk("mode", 16'(f), 16'(fwm));
	endtask
	task automatic op(input logic [6:0] t, input logic r, input logic [6:0] a,
		input logic [7:0] d);
		logic hit;
		int   n;
		hit = 1'h0;
		tgt <= t;
		rrd <= r;
		rreg <= a;
		rdat <= d;
		rv <= 1'h1;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (rdy !== 1'h1 && n < 100);
		if (n >= 100) begin
			errors++;
			results();
		end
		@(posedge clk);
		rv <= 1'h0;
		// Enable set with the call only settles here, so decide now
		hit = fw || t == {STRAP_BASE, strap} || (t == GLOBAL_ADDR && gen);
		do begin
			@(negedge clk);
			n++;
		end while (rsv !== 1'h1 && n < 5000);
		if (n >= 5000) begin
			errors++;
			results();
		end
		repeat (20) @(posedge clk);
		if (!fw) chk("nack", 16'(!hit), 16'(rsn));
		if (r && hit) chk("read", 16'(mem[a]), 16'(rsd));
		if (!r && hit) mem[a] = d;
		chk("stores", 16'(!r && hit), 16'(wq.size()));
		if (wq.size() > 0) chk("store", {1'h0, a, d}, {1'h0, wq[0]});
		wq.delete();
	endtask
	initial begin
		seed = 62088;
		errors = 0;
		total_checks = 0;
		srst = 1'h1;
		ce = 1'h1;
		strap = 2'h0;
		gen = 1'h1;
		fw = 1'h0;
		tgt = 7'h00;
		rv = 1'h0;
		rrd = 1'h0;
		rreg = 7'h00;
		rdat = 8'h00;
		ra = 7'h01;
		lk.select_strap = 1'h0;
		boot(1'h0);
		for (int i = 0; i < 5; i++) begin
			ra = 7'($unsigned($random(seed)) % 126 + 1);
			op({STRAP_BASE, strap}, 1'h0, ra, 8'($random(seed)));
			op({STRAP_BASE, strap}, 1'h1, ra, 8'h00);
		end
		for (int k = 0; k < 4; k++) begin
			op({STRAP_BASE, 2'(k)}, 1'h0, 7'h40 + 7'(k), 8'($random(seed)));
		end
		op(GLOBAL_ADDR, 1'h0, 7'h10, 8'($random(seed)));
		gen <= 1'h0;
		op(GLOBAL_ADDR, 1'h0, 7'h11, 8'($random(seed)));
		gen <= 1'h1;
		op(GLOBAL_ADDR, 1'h1, 7'h10, 8'h00);
		$display("two-wire test done");
		boot(1'h1);
		op(7'h00, 1'h1, 7'h7e, 8'h00);
		for (int i = 0; i < 5; i++) begin
			ra = (i == 0) ? 7'h7e : 7'($unsigned($random(seed)) % 126 + 1);
			op(7'h00, 1'h0, ra, 8'($random(seed)));
			op(7'h00, 1'h1, ra, 8'h00);
		end
		$display("four-wire test done");
		results();
	end
endmodule
`default_nettype wire
